// ### bench/dgic_glass_model.sv
/*
  behavioural glass panel: latches the data bus each clock.
  assumes the glass only listens while the block marks it active.
*/
`timescale 1ns/100ps
module dgic_glass_model (
  input wire logic i_sys_clk,
  input wire logic i_active,
  input wire logic [15:0] i_data,
  output logic [15:0] o_seen
);
  // display off
  // an inactive glass shows a marker, never stale pixels
  always_ff @(posedge i_sys_clk) begin
    o_seen <= i_active ? i_data : 16'hDEAD;
  end
endmodule

// ### bench/dgic_top_properties.sv
/*
  port assertions for the display glass configuration block.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module dgic_top_properties (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic o_glass_active,
  input wire logic [4:0] o_bits_per_pixel
);
  // ********************************
  // properties
  // ********************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [3:0] raddr_q; // address of the read in flight
  // track read address so answers can be judged by target
  always_ff @(posedge i_sys_clk) begin
    if (i_arvalid && o_arready) raddr_q <= i_araddr;
  end
  property p_reset_clear;
    $fell(i_reset) |-> !o_glass_active && o_bits_per_pixel == 5'h0 && !o_bvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
  property p_depth_legal;
    o_bits_per_pixel inside {5'h0, 5'h1, 5'h2, 5'h4, 5'h8, 5'h10};
  endproperty
  a_depth_legal: assert property (p_depth_legal) else $error("bad pixel depth");
  property p_upper_zero;
    o_rvalid |-> o_rdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_cfg_unimpl;
    o_rvalid && raddr_q == 4'h4 |-> (o_rdata[15:0] & 16'h0C18) == 16'h0;
  endproperty
  a_cfg_unimpl: assert property (p_cfg_unimpl) else $error("unimplemented bit set");
  property p_status_mirror;
    o_rvalid && raddr_q == 4'h8 |-> o_rdata[7] == o_glass_active
      && o_rdata[4:0] == o_bits_per_pixel;
  endproperty
  a_status_mirror: assert property (p_status_mirror) else $error("status mismatch");
  property p_bvalid_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
  property p_rvalid_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");
  property p_read_answer;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_unmapped;
    o_rvalid && !(raddr_q inside {4'h0, 4'h4, 4'h8}) |-> o_rresp == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule
bind dgic_top dgic_top_properties dgic_top_properties_i (.i_sys_clk, .i_reset, .i_araddr,
  .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_bresp, .o_bvalid,
  .i_bready, .o_glass_active, .o_bits_per_pixel);

// ### bench/dgic_top_test.sv
/*
  self-checking bench for the display glass configuration block.
  assumes the checker binds itself and the glass model stands beside.
*/
`timescale 1ns/100ps
`include "dgic_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dgic_top_test;
  // ********************************
  // stimulus and checks
  // ********************************
  logic clk, rst, awv, wv, bre, arv, rre, pv;
  logic [3:0] awa, ara;
  logic [31:0] wd, got;
  logic [15:0] pix;
  logic [1:0] resp;
  wire logic awr, wrd, bv, arr, rv, ga;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdt;
  wire logic [15:0] gd, seen;
  wire logic [4:0] bpp;
  int failures = 0, comparisons = 0;
  dgic_top #(.HPIX(8), .VPIX(4)) dgic_top_i (.i_sys_clk(clk), .i_reset(rst),
    .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
    .i_wvalid(wv), .o_wready(wrd), .o_bresp(br), .o_bvalid(bv), .i_bready(bre),
    .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdt), .o_rresp(rr),
    .o_rvalid(rv), .i_rready(rre), .i_pixel(pix), .i_pixel_valid(pv),
    .o_glass_data(gd), .o_glass_active(ga), .o_bits_per_pixel(bpp));
  dgic_glass_model dgic_glass_model_i (.i_sys_clk(clk), .i_active(ga), .i_data(gd),
    .o_seen(seen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    resp = br;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    got = rdt;
    resp = rr;
  endtask
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    {awv, wv, bre, arv, rre, pv} = '0;
    {awa, ara, wd, pix} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(4'(4 * i));
      `CHK(got, (i == 2) ? 32'h1 : 32'h0)
    end
    wr(`DGIC_OFS_GLASS_CFG, 32'hFFFFFFFF);
    rd(`DGIC_OFS_GLASS_CFG);
    `CHK(got, 32'h0000F3E7)
    wr(`DGIC_OFS_GFX_CTRL1, 32'hFFFFFFFF);
    rd(`DGIC_OFS_GFX_CTRL1);
    `CHK(got, 32'h000000E0)
    rd(4'hC);
    `CHK(resp, 2'h2)
    wr(4'hC, 32'h0);
    `CHK(resp, 2'h2)
    // both depth fields kept equal, tft selected
    for (int k = 0; k < 5; k++) begin
      wr(`DGIC_OFS_GFX_CTRL1, 32'(k) << 5);
      wr(`DGIC_OFS_GLASS_CFG, (32'(k) << 5) | 32'h1);
      rd(`DGIC_OFS_STATUS);
      `CHK(got, 32'h80 | (32'h1 << k))
      `CHK(bpp, 5'(1 << k))
    end
    for (int t = 0; t < 8; t++) begin
      wr(`DGIC_OFS_GLASS_CFG, 32'(t));
      rd(`DGIC_OFS_STATUS);
      `CHK(got[7], 1'(t >= 1 && t <= 3))
      `CHK(ga, 1'(t >= 1 && t <= 3))
    end
    pv <= 1'b1;
    pix <= 16'hA5C3;
    wr(`DGIC_OFS_GLASS_CFG, 32'h0001);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'hA5C3)
    wr(`DGIC_OFS_GLASS_CFG, 32'h8002);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'hA5C3)
    wr(`DGIC_OFS_GLASS_CFG, 32'h0101);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'h0000)
    // narrow buses keep only their low lines
    wr(`DGIC_OFS_GLASS_CFG, 32'h0002);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'h0003)
    wr(`DGIC_OFS_GLASS_CFG, 32'h4002);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'h00C3)
    // group stagger: a rising step reaches the groups half a clock apart
    pix <= 16'h0000;
    wr(`DGIC_OFS_GLASS_CFG, 32'h3001);
    repeat (6) @(posedge clk);
    pix <= 16'hFFFF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(gd, 16'h1111)
    @(negedge clk);
    `CHK(gd, 16'h3333)
    @(negedge clk);
    `CHK(gd, 16'h7777)
    @(negedge clk);
    `CHK(gd, 16'hFFFF)
    // even bits lag a full clock on a falling step
    wr(`DGIC_OFS_GLASS_CFG, 32'h2001);
    repeat (6) @(posedge clk);
    pix <= 16'h0000;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(gd, 16'h5555)
    @(negedge clk);
    `CHK(gd, 16'h5555)
    @(negedge clk);
    `CHK(gd, 16'h0000)
    // odd bits lag half a clock on a rising step
    wr(`DGIC_OFS_GLASS_CFG, 32'h1001);
    repeat (6) @(posedge clk);
    pix <= 16'hFFFF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(gd, 16'h5555)
    @(negedge clk);
    `CHK(gd, 16'hFFFF)
    // reset in mid-run, raster then frozen at its origin
    @(posedge clk);
    pv <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`DGIC_OFS_GLASS_CFG);
    `CHK(got, 32'h0)
    repeat (4) @(posedge clk);
    `CHK(seen, 16'hDEAD)
    wr(`DGIC_OFS_GLASS_CFG, 32'h0301);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'hFFFF)
    wr(`DGIC_OFS_GLASS_CFG, 32'h0201);
    repeat (8) @(posedge clk);
    `CHK(seen, 16'h1555)
    close_out;
  end
endmodule

// ### design/dgic_defines.svh
/*
  constants for the display glass interface configuration block:
  register offsets, field positions, reset values and code points.
  assumes nothing; definitions only.
*/
`ifndef DGIC_DEFINES_SVH
`define DGIC_DEFINES_SVH
// ********************************
// register byte offsets
// ********************************
`define DGIC_OFS_GFX_CTRL1 4'h0
`define DGIC_OFS_GLASS_CFG 4'h4
`define DGIC_OFS_STATUS 4'h8
// ********************************
// field positions
// ********************************
`define DGIC_WIDTH_LSB 14
`define DGIC_SKEW_LSB 12
`define DGIC_TEST_LSB 8
`define DGIC_PDEPTH_LSB 5
`define DGIC_GTYPE_LSB 0
`define DGIC_CFG_IMPL_MASK 16'hF3E7
`define DGIC_CTRL1_IMPL_MASK 16'h00E0
// ********************************
// reset values
// ********************************
`define DGIC_CFG_RESET 16'h0000
`define DGIC_CTRL1_RESET 16'h0000
// ********************************
// bus responses
// ********************************
`define DGIC_RESP_OKAY 2'h0
`define DGIC_RESP_SLVERR 2'h2
`endif

// ### design/dgic_pkg.sv
/*
  types for the display glass interface configuration block.
  assumes dgic_defines.svh is compiled alongside.
*/
package dgic_pkg;
  // glass data bus width code
  typedef enum logic [1:0] {DGIC_W4, DGIC_W8, DGIC_W16, DGIC_WRSV} dgic_width_t;
  // bit skew scheme code
  typedef enum logic [1:0] {DGIC_SK_NONE, DGIC_SK_ODD, DGIC_SK_EVEN, DGIC_SK_GROUP} dgic_skew_t;
  // test pattern code
  typedef enum logic [1:0] {DGIC_TP_NORMAL, DGIC_TP_BLACK, DGIC_TP_BARS, DGIC_TP_BORDER}
    dgic_test_t;
  // glass type code
  typedef enum logic [2:0] {DGIC_GT_OFF, DGIC_GT_TFT, DGIC_GT_MONO, DGIC_GT_COLOR,
    DGIC_GT_R4, DGIC_GT_R5, DGIC_GT_R6, DGIC_GT_R7} dgic_gtype_t;
endpackage

// ### design/dgic_skew.sv
/*
  skews the 16 glass data bits per the selected scheme using both
  edges emulated by a half-rate phase enable from the parent.
  assumes i_half_en pulses each half graphics clock period.
*/
`timescale 1ns/100ps
module dgic_skew
  import dgic_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_half_en,
  input wire logic [1:0] i_skew,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);
  // all state: delay taps at half-clock steps and the output register
  typedef struct packed {
    logic [WIDTH-1:0] d1;
    logic [WIDTH-1:0] d2;
    logic [WIDTH-1:0] d3;
    logic [WIDTH-1:0] out;
  } dgic_skew_state_t;
  dgic_skew_state_t st_q, st_d;
  // ********************************
  // tap selection
  // ********************************
  always_comb begin
    st_d = st_q;
    if (i_half_en) begin
      st_d.d1 = i_data;
      st_d.d2 = st_q.d1;
      st_d.d3 = st_q.d2;
    end
    for (int i = 0; i < WIDTH; i++) begin
      unique case (i_skew)
        2'h3: st_d.out[i] = (i % 4 == 0) ? i_data[i] : (i % 4 == 1) ? st_q.d1[i] :
                            (i % 4 == 2) ? st_q.d2[i] : st_q.d3[i];
        2'h2: st_d.out[i] = (i % 2 == 0) ? st_q.d2[i] : i_data[i];
        // odd bits half clock
        2'h1: st_d.out[i] = (i % 2 == 1) ? st_q.d1[i] : i_data[i];
        default: st_d.out[i] = i_data[i];
      endcase
    end
  end
  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_data = st_q.out;
endmodule

// ### design/dgic_top.sv
/*
  display glass interface configuration: axi4-lite register file
  holding the glass configuration and render pixel depth, and pixel
  output shaping (width, test pattern, skew) toward the glass pins.
  assumes one 100 MHz clock; pixels arrive synchronous to it.
*/
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "dgic_defines.svh"
module dgic_top
  import dgic_pkg::*;
#(
  parameter int HPIX = 320,
  parameter int VPIX = 240
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [15:0] i_pixel,
  input wire logic i_pixel_valid,
  output logic [15:0] o_glass_data,
  output logic o_glass_active,
  output logic [4:0] o_bits_per_pixel
);
  // all state of the block apart from the skew stage, which keeps its own
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] ctrl1;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic half_en;
    logic [9:0] hcnt;
    logic [9:0] vcnt;
    logic [15:0] pix;
    logic active;
    logic [4:0] bpp;
    logic awready; // registered copy of not aw_got
    logic wready; // registered copy of not w_got
    logic arready; // registered copy of not rvalid
  } dgic_state_t;
  dgic_state_t st_q, st_d;
  dgic_width_t width_eff; // effective bus width
  dgic_gtype_t gtype; // glass type field
  dgic_test_t tpat; // pattern field
  logic [15:0] wmerge; // write data merged by byte lanes
  logic [15:0] rd_word; // register read mux
  logic rd_hit; // read address decodes
  logic [15:0] skewed; // skew stage output
  // ********************************
  // field decode
  // ********************************
  always_comb begin
    gtype = dgic_gtype_t'(st_q.cfg[`DGIC_GTYPE_LSB +: 3]);
    tpat = dgic_test_t'(st_q.cfg[`DGIC_TEST_LSB +: 2]);
    if (gtype == DGIC_GT_TFT) begin
      width_eff = DGIC_W16;
    end else begin
      width_eff = dgic_width_t'(st_q.cfg[`DGIC_WIDTH_LSB +: 2]);
    end
  end
  // ********************************
  // register read mux
  // ********************************
  always_comb begin
    rd_hit = 1'b1;
    unique case (i_araddr)
      `DGIC_OFS_GLASS_CFG: rd_word = st_q.cfg & `DGIC_CFG_IMPL_MASK;
      `DGIC_OFS_GFX_CTRL1: rd_word = st_q.ctrl1 & `DGIC_CTRL1_IMPL_MASK;
      `DGIC_OFS_STATUS: rd_word = {8'h00, st_q.active, 2'h0, st_q.bpp};
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic [15:0] old;
    old = 16'h0000;
    st_d = st_q;
    // write address and data taken in either order
    if (i_awvalid && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st_q.w_got) begin
      st_d.w_got = 1'b1;
      st_d.w_data = i_wdata;
      st_d.w_strb = i_wstrb;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      old = (st_q.aw_addr == `DGIC_OFS_GFX_CTRL1) ? st_q.ctrl1 : st_q.cfg;
      wmerge[7:0] = st_q.w_strb[0] ? st_q.w_data[7:0] : old[7:0];
      wmerge[15:8] = st_q.w_strb[1] ? st_q.w_data[15:8] : old[15:8];
      st_d.bresp = `DGIC_RESP_OKAY;
      if (st_q.aw_addr == `DGIC_OFS_GLASS_CFG) begin
        st_d.cfg = wmerge & `DGIC_CFG_IMPL_MASK;
      end else if (st_q.aw_addr == `DGIC_OFS_GFX_CTRL1) begin
        st_d.ctrl1 = wmerge & `DGIC_CTRL1_IMPL_MASK;
      end else if (st_q.aw_addr != `DGIC_OFS_STATUS) begin
        st_d.bresp = `DGIC_RESP_SLVERR;
      end
      st_d.bvalid = 1'b1;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
    end else begin
      wmerge = 16'h0000;
    end
    if (st_q.bvalid && i_bready) begin
      st_d.bvalid = 1'b0;
    end
    // read answers one cycle after the address is taken
    if (st_q.rvalid && i_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (i_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = {16'h0000, rd_word};
      st_d.rresp = rd_hit ? `DGIC_RESP_OKAY : `DGIC_RESP_SLVERR;
    end
    // readies kept in flip-flops so every bus output leaves a register
    st_d.awready = !st_d.aw_got;
    st_d.wready = !st_d.w_got;
    st_d.arready = !st_d.rvalid;
    // one system clock is half a graphics clock, so the skew taps step
    // every cycle; they stand still in reset and in the first cycle after it, while half_en still holds its reset 0
    st_d.half_en = 1'b1;
    // raster position for patterns
    if (i_pixel_valid) begin
      if (st_q.hcnt == 10'(HPIX - 1)) begin
        st_d.hcnt = 10'h000;
        st_d.vcnt = (st_q.vcnt == 10'(VPIX - 1)) ? 10'h000 : st_q.vcnt + 10'h001;
      end else begin
        st_d.hcnt = st_q.hcnt + 10'h001;
      end
    end
    unique case (tpat)
      DGIC_TP_NORMAL: st_d.pix = i_pixel;
      DGIC_TP_BLACK: st_d.pix = 16'h0000;
      DGIC_TP_BARS: st_d.pix = {16{st_q.hcnt[6]}} ^ {st_q.hcnt[9:7], 13'h1555};
      DGIC_TP_BORDER: st_d.pix = (st_q.hcnt == 10'h000 || st_q.vcnt == 10'h000 ||
                                  st_q.hcnt == 10'(HPIX - 1) || st_q.vcnt == 10'(VPIX - 1))
                                 ? 16'hFFFF : 16'h0000;
    endcase
    unique case (width_eff)
      DGIC_W4: st_d.pix = st_d.pix & 16'h000F;
      DGIC_W8: st_d.pix = st_d.pix & 16'h00FF;
      default: st_d.pix = st_d.pix;
    endcase
    st_d.active = (gtype == DGIC_GT_TFT) || (gtype == DGIC_GT_MONO) ||
                  (gtype == DGIC_GT_COLOR);
    if (!st_d.active) begin
      st_d.pix = 16'h0000;
    end
    unique case (st_q.cfg[`DGIC_PDEPTH_LSB +: 3])
      3'h0: st_d.bpp = 5'h01;
      3'h1: st_d.bpp = 5'h02;
      3'h2: st_d.bpp = 5'h04;
      3'h3: st_d.bpp = 5'h08;
      3'h4: st_d.bpp = 5'h10;
      default: st_d.bpp = 5'h00;
    endcase
  end
  // ********************************
  // state register
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
      st_q.cfg <= `DGIC_CFG_RESET;
      st_q.ctrl1 <= `DGIC_CTRL1_RESET;
      // channels are free again at the reset edge
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
  // ********************************
  // skew stage
  // ********************************
  dgic_skew #(.WIDTH(16)) u_skew (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_half_en(st_q.half_en),
    .i_skew(st_q.cfg[`DGIC_SKEW_LSB +: 2]),
    .i_data(st_q.pix),
    .o_data(skewed)
  );
  // outputs straight from flip-flops
  assign o_glass_data = skewed;
  assign o_glass_active = st_q.active;
  assign o_bits_per_pixel = st_q.bpp;
  assign o_awready = st_q.awready;
  assign o_wready = st_q.wready;
  assign o_bvalid = st_q.bvalid;
  assign o_bresp = st_q.bresp;
  assign o_arready = st_q.arready;
  assign o_rvalid = st_q.rvalid;
  assign o_rdata = st_q.rdata;
  assign o_rresp = st_q.rresp;
endmodule
